/* File: design/line_ctl_pkg.sv */
/*
 Constants for the line-side control and threshold interrupt register slice.
 Assumes a single 50 MHz clock and a plain address/strobe register port.
*/
package line_ctl_pkg;
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_CTRL4 = 6'h1F;
	localparam logic [5:0] OFS_RSVD_FIRST = 6'h20;
	localparam logic [5:0] OFS_RSVD_LAST = 6'h2A;
	localparam logic [5:0] OFS_THRESH = 6'h2B;
	localparam logic [5:0] OFS_IRQ_CTRL = 6'h2C;
	localparam logic [5:0] OFS_AUX_CTRL = 6'h30;
	localparam int POS_FOH_LO = 5;
	localparam int POS_HANGUP_SPEED_SEL_B = 3;
	localparam int POS_RX_CORNER_SEL = 1;
	localparam int POS_ZERO_CLAMP_DISABLE = 0;
	localparam logic [7:0] CTRL4_WMASK = 8'h6B;
	localparam int POS_FLAG = 3;
	localparam int POS_SRC = 2;
	localparam int POS_MASK = 1;
	localparam int POS_DIR = 0;
	localparam int POS_AUX_SEIZE = 0;
	localparam int POS_AUX_OHS = 1;
	localparam int POS_AUX_SQ_LO = 2;
	localparam int POS_AUX_GLOBAL_IRQ_EN = 4;
	localparam logic [1:0] FOH_RESET = 2'h1;
	localparam logic [7:0] THRESH_RESET = 8'h00;
	localparam logic [7:0] CLAMP_VOLTS = 8'h03;
	localparam int CLK_MHZ = 50;
	localparam int FOH_MS_0 = 512;
	localparam int FOH_MS_1 = 128;
	localparam int FOH_MS_2 = 64;
	localparam int FOH_MS_3 = 8;
	localparam int HANGUP_FAST_US = 500;
	localparam int HANGUP_MID_US = 3000;
	localparam int HANGUP_SLOW_US = 26000;
	localparam int FOH_CYC_0 = FOH_MS_0 * 1000 * CLK_MHZ;
	localparam int FOH_CYC_1 = FOH_MS_1 * 1000 * CLK_MHZ;
	localparam int FOH_CYC_2 = FOH_MS_2 * 1000 * CLK_MHZ;
	localparam int FOH_CYC_3 = FOH_MS_3 * 1000 * CLK_MHZ;
	localparam int HANGUP_FAST_CYC = HANGUP_FAST_US * CLK_MHZ - 1;
	localparam int HANGUP_MID_CYC = HANGUP_MID_US * CLK_MHZ;
	localparam int HANGUP_SLOW_CYC = HANGUP_SLOW_US * CLK_MHZ;
	typedef enum logic [2:0] {
		HOOK_ON = 3'b001,
		HOOK_SEIZE = 3'b010,
		HOOK_RELEASE = 3'b100
	} hook_state_e;
endpackage : line_ctl_pkg

/* File: design/threshold_cmp.sv */
/*
 Threshold compare of one 8-bit reading, with absolute value for signed readings.
 Assumes readings are stable in the clock domain.
*/
`timescale 1ns/100ps
module threshold_cmp
(
	input wire logic [7:0] reading_i,
	input wire logic is_signed_i,
	input wire logic [7:0] threshold_i,
	input wire logic rise_i,
	output logic hit_o
);
	logic [7:0] mag;

	always_comb
	begin
		// two's complement magnitude for the voltage reading
		if (is_signed_i && reading_i[7])
			mag = 8'(~reading_i + 8'h01);
		else
			mag = reading_i;
		if (rise_i)
			hit_o = mag > threshold_i;
		else
			hit_o = mag < threshold_i;
	end
endmodule : threshold_cmp

/* File: design/line_ctl_regs.sv */
/*
 Register slice: control 4, reserved block, monitor threshold and its interrupt control,
 plus one hook timing counter. Assumes synchronous readings and a strobe register port.
*/
`timescale 1ns/100ps
module line_ctl_regs
#(
	parameter int FOH_CYC_0_P = line_ctl_pkg::FOH_CYC_0,
	// shorter lengths keep the longest one's scale, so one override retimes all four
	parameter int FOH_CYC_1_P = FOH_CYC_0_P / line_ctl_pkg::FOH_MS_0 * line_ctl_pkg::FOH_MS_1,
	parameter int FOH_CYC_2_P = FOH_CYC_0_P / line_ctl_pkg::FOH_MS_0 * line_ctl_pkg::FOH_MS_2,
	parameter int FOH_CYC_3_P = FOH_CYC_0_P / line_ctl_pkg::FOH_MS_0 * line_ctl_pkg::FOH_MS_3,
	parameter int HANGUP_MID_P = line_ctl_pkg::HANGUP_MID_CYC,
	parameter int HANGUP_SLOW_P = line_ctl_pkg::HANGUP_SLOW_CYC
)
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [line_ctl_pkg::ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [7:0] loop_amp_reading_i,
	input wire logic [7:0] line_volt_raw_i,
	output logic [7:0] line_volt_reading_o,
	output logic rx_corner_sel_o,
	output logic line_seize_o,
	output logic offhook_done_o,
	output logic hangup_done_o,
	output logic irq_o
);
	import line_ctl_pkg::*;

	logic [1:0] fast_offhook_len_sel;
	logic hangup_speed_sel_a;
	logic hangup_speed_sel_b;
	logic [1:0] spark_quench_sel;
	logic line_seize_ctl;
	logic rx_corner_sel;
	logic zero_clamp_disable;
	logic [7:0] monitor_threshold;
	logic threshold_crossed_flag;
	logic monitor_source_sel;
	logic threshold_irq_mask;
	logic threshold_direction;
	logic global_irq_en;
	logic [7:0] line_volt_reading;
	logic [7:0] selected;
	logic hit;
	logic hit_q;
	logic trigger;
	logic [31:0] count;
	logic [31:0] offhook_target;
	logic [31:0] hangup_target;
	hook_state_e hook_state;
	hook_state_e next_hook_state;
	logic wr_ctrl;
	logic wr_thresh;
	logic wr_irq;
	logic wr_aux;
	logic seize_prev;

	assign wr_ctrl = wr_i && (addr_i == OFS_CTRL4);
	assign wr_thresh = wr_i && (addr_i == OFS_THRESH);
	assign wr_irq = wr_i && (addr_i == OFS_IRQ_CTRL);
	assign wr_aux = wr_i && (addr_i == OFS_AUX_CTRL);

	// control 4: only writable fields stored, reserved bits have no flops
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			fast_offhook_len_sel <= FOH_RESET;
			hangup_speed_sel_b <= 1'b0;
			rx_corner_sel <= 1'b0;
			zero_clamp_disable <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			fast_offhook_len_sel <= wdata_i[POS_FOH_LO+1:POS_FOH_LO];
			hangup_speed_sel_b <= wdata_i[POS_HANGUP_SPEED_SEL_B];
			rx_corner_sel <= wdata_i[POS_RX_CORNER_SEL];
			zero_clamp_disable <= wdata_i[POS_ZERO_CLAMP_DISABLE];
		end
	end

	// bits that live elsewhere in the device, gathered here
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			line_seize_ctl <= 1'b0;
			hangup_speed_sel_a <= 1'b0;
			spark_quench_sel <= 2'h0;
			global_irq_en <= 1'b0;
		end
		else if (wr_aux)
		begin
			line_seize_ctl <= wdata_i[POS_AUX_SEIZE];
			hangup_speed_sel_a <= wdata_i[POS_AUX_OHS];
			spark_quench_sel <= wdata_i[POS_AUX_SQ_LO+1:POS_AUX_SQ_LO];
			global_irq_en <= wdata_i[POS_AUX_GLOBAL_IRQ_EN];
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			monitor_threshold <= THRESH_RESET;
		else if (wr_thresh)
			monitor_threshold <= wdata_i;
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			monitor_source_sel <= 1'b0;
			threshold_irq_mask <= 1'b0;
			threshold_direction <= 1'b0;
		end
		else if (wr_irq)
		begin
			monitor_source_sel <= wdata_i[POS_SRC];
			threshold_irq_mask <= wdata_i[POS_MASK];
			threshold_direction <= wdata_i[POS_DIR];
		end
	end

	// clamp low voltages to zero unless disabled
	always_comb
	begin
		logic [7:0] mag;
		mag = line_volt_raw_i[7] ? 8'(~line_volt_raw_i + 8'h01) : line_volt_raw_i;
		if (!zero_clamp_disable && mag <= CLAMP_VOLTS)
			line_volt_reading = 8'h00;
		else
			line_volt_reading = line_volt_raw_i;
	end

	assign selected = monitor_source_sel ? line_volt_reading : loop_amp_reading_i;

	threshold_cmp u_cmp
	(
		.reading_i(selected),
		.is_signed_i(monitor_source_sel),
		.threshold_i(monitor_threshold),
		.rise_i(threshold_direction),
		.hit_o(hit)
	);

	// edge of the compare: a crossing, not a steady level, is the event
	assign trigger = hit && !hit_q;

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			hit_q <= 1'b0;
		else
			hit_q <= hit;
	end

	// set wins over a same-cycle clear
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			threshold_crossed_flag <= 1'b0;
		else if (trigger)
			threshold_crossed_flag <= 1'b1;
		else if (wr_irq && !wdata_i[POS_FLAG])
			threshold_crossed_flag <= 1'b0;
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= threshold_crossed_flag && threshold_irq_mask && global_irq_en;
	end

	always_comb
	begin
		case (fast_offhook_len_sel)
			2'h0: offhook_target = 32'(FOH_CYC_0_P);
			2'h1: offhook_target = 32'(FOH_CYC_1_P);
			2'h2: offhook_target = 32'(FOH_CYC_2_P);
			default: offhook_target = 32'(FOH_CYC_3_P);
		endcase
	end

	// unlisted combinations fall back to the fastest release
	always_comb
	begin
		if (hangup_speed_sel_a && spark_quench_sel == 2'h3)
			hangup_target = 32'(HANGUP_SLOW_P);
		else if (!hangup_speed_sel_a && hangup_speed_sel_b && spark_quench_sel == 2'h0)
			hangup_target = 32'(HANGUP_MID_P);
		else
			hangup_target = 32'(HANGUP_FAST_CYC);
	end

	always_comb
	begin
		next_hook_state = hook_state;
		case (hook_state)
			HOOK_ON:
				if (line_seize_ctl)
					next_hook_state = HOOK_SEIZE;
			HOOK_SEIZE:
				if (!line_seize_ctl)
					next_hook_state = HOOK_RELEASE;
			HOOK_RELEASE:
				if (line_seize_ctl)
					next_hook_state = HOOK_SEIZE;
				else if (loop_amp_reading_i == 8'h00 && count >= hangup_target)
					next_hook_state = HOOK_ON;
			default:
				next_hook_state = HOOK_ON;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			hook_state <= HOOK_ON;
		else
			hook_state <= next_hook_state;
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			seize_prev <= 1'b0;
		else
			seize_prev <= line_seize_ctl;
	end

	// one counter serves both phases; restarted on each seize change
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			count <= 32'h0000_0000;
		else if (line_seize_ctl != seize_prev)
			count <= 32'h0000_0000;
		else if (count != 32'hFFFF_FFFF)
			count <= count + 32'h0000_0001;
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			offhook_done_o <= 1'b0;
			hangup_done_o <= 1'b0;
		end
		else
		begin
			offhook_done_o <= hook_state == HOOK_SEIZE && line_seize_ctl == seize_prev
				&& count >= offhook_target;
			hangup_done_o <= hook_state == HOOK_RELEASE && next_hook_state == HOOK_ON;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			line_volt_reading_o <= 8'h00;
			rx_corner_sel_o <= 1'b0;
			line_seize_o <= 1'b0;
		end
		else
		begin
			line_volt_reading_o <= line_volt_reading;
			rx_corner_sel_o <= rx_corner_sel;
			line_seize_o <= line_seize_ctl;
		end
	end

	// reserved and unmapped addresses read zero
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_o <= 8'h00;
		else if (rd_i)
		begin
			case (addr_i)
				OFS_CTRL4:
					rdata_o <= {1'b0, fast_offhook_len_sel, 1'b0, hangup_speed_sel_b, 1'b0,
						rx_corner_sel, zero_clamp_disable} & CTRL4_WMASK;
				OFS_THRESH:
					rdata_o <= monitor_threshold;
				OFS_IRQ_CTRL:
					rdata_o <= {4'h0, threshold_crossed_flag, monitor_source_sel,
						threshold_irq_mask, threshold_direction};
				OFS_AUX_CTRL:
					rdata_o <= {3'h0, global_irq_en, spark_quench_sel, hangup_speed_sel_a, line_seize_ctl};
				default:
					rdata_o <= 8'h00;
			endcase
		end
		else
			rdata_o <= 8'h00;
	end
endmodule : line_ctl_regs

/* File: verification/line_ctl_regs_checker.sv */
/*
 Port checker for line_ctl_regs: read port, clamp, irq gating, release pulse.
 Assumes one clock domain; bound to every line_ctl_regs instance below.
*/
`timescale 1ns/100ps
module line_ctl_regs_checker
import line_ctl_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [line_ctl_pkg::ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [7:0] loop_amp_reading_i,
	input wire logic [7:0] line_volt_raw_i,
	input wire logic [7:0] line_volt_reading_o,
	input wire logic hangup_done_o,
	input wire logic irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence thr_wr_rd;
		wr_i && addr_i == OFS_THRESH ##1 !wr_i ##1 rd_i && addr_i == OFS_THRESH;
	endsequence
	sequence mask_off;
		wr_i && addr_i == OFS_IRQ_CTRL && !wdata_i[POS_MASK];
	endsequence
	rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("read data not idle");
	rsvd_zero_a: assert property (rd_i && addr_i >= OFS_RSVD_FIRST && addr_i <= OFS_RSVD_LAST
		|=> rdata_o == 8'h00) else $error("reserved read not zero");
	ctrl_rsvd_a: assert property (rd_i && addr_i == OFS_CTRL4 |=> (rdata_o & ~CTRL4_WMASK) == 8'h00)
		else $error("reserved control bit set");
	thr_back_a: assert property (thr_wr_rd |=> rdata_o == $past(wdata_i, 3))
		else $error("threshold readback wrong");
	clamp_zero_a: assert property (line_volt_raw_i == 8'h00 |=> line_volt_reading_o == 8'h00)
		else $error("zero voltage not zero");
	clamp_pass_a: assert property ($signed(line_volt_raw_i) > 3 || $signed(line_volt_raw_i) < -3
		|=> line_volt_reading_o == $past(line_volt_raw_i)) else $error("voltage altered");
	mask_gate_a: assert property (mask_off |=> ##1 !irq_o) else $error("irq while masked");
	enable_gate_a: assert property (wr_i && addr_i == OFS_AUX_CTRL && !wdata_i[POS_AUX_GLOBAL_IRQ_EN]
		|=> ##1 !irq_o) else $error("irq while disabled");
	release_pulse_a: assert property (hangup_done_o |=> !hangup_done_o)
		else $error("release pulse too long");
	release_zero_a: assert property (hangup_done_o |-> $past(loop_amp_reading_i) == 8'h00)
		else $error("release with current");
endmodule : line_ctl_regs_checker

bind line_ctl_regs line_ctl_regs_checker chk (.ref_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .loop_amp_reading_i, .line_volt_raw_i, .line_volt_reading_o, .hangup_done_o, .irq_o);

/* File: verification/test_line_side_control_and_threshold_irq.sv */
/*
 Self-checking bench for line_ctl_regs: map, hook timers, clamp, threshold irq.
 Assumes the bound checker file; hook counts except the fast release shortened by parameters.
*/
`timescale 1ns/100ps
module test_line_side_control_and_threshold_irq;
	import line_ctl_pkg::*;
	logic ref_clk_i, reset_n_i, wr_i, rd_i, rx_corner_sel_o, line_seize_o, offhook_done_o, hangup_done_o, irq_o;
	logic [5:0] addr_i;
	logic [7:0] wdata_i, rdata_o, amp, raw, line_volt_reading_o, seed;
	int failures, samples_checked, k, thr, src, dir, msk, en, cdis, flag, hit_q;
	// one cycle per millisecond of off-hook length
	int lens[4] = '{FOH_MS_0, FOH_MS_1, FOH_MS_2, FOH_MS_3};
	line_ctl_regs #(.FOH_CYC_0_P(FOH_MS_0),
		.HANGUP_MID_P(15), .HANGUP_SLOW_P(25)) dut (.ref_clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .loop_amp_reading_i(amp), .line_volt_raw_i(raw), .line_volt_reading_o,
		.rx_corner_sel_o, .line_seize_o, .offhook_done_o, .hangup_done_o, .irq_o);
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic logic [7:0] clampv(input logic [7:0] r);
		return (cdis == 0 && $signed(r) <= 3 && $signed(r) >= -3) ? 8'h00 : r;
	endfunction : clampv
	function automatic int hitf(input logic [7:0] a, input logic [7:0] r);
		int h;
		logic [7:0] c;
		c = clampv(r);
		h = src ? (c[7] ? 256 - c : c) : a;
		return dir ? h > thr : h < thr;
	endfunction : hitf
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input string s, input logic [5:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 chk(s, e, rdata_o);
	endtask : rd
	task automatic waitfor(input int sel, input int lim);
		k = 0;
		while (!(sel ? hangup_done_o : offhook_done_o) && k < lim)
		begin
			@(posedge ref_clk_i);
			k++;
		end
	endtask : waitfor
	task automatic step(input logic [7:0] a, input logic [7:0] r);
		int h;
		@(posedge ref_clk_i);
		amp <= a;
		raw <= r;
		repeat (3) @(posedge ref_clk_i);
		h = hitf(a, r);
		if (h && !hit_q) flag = 1;
		hit_q = h;
		#1 chk("irq", 8'(flag && msk && en), {7'h00, irq_o});
		chk("volt", clampv(r), line_volt_reading_o);
		rd("irq_ctrl", OFS_IRQ_CTRL, 8'(flag * 8 + src * 4 + msk * 2 + dir));
	endtask : step
	// irq ctrl written twice so edges from the half-written setup are flushed
	task automatic cfg(input int t, input int s, input int m, input int d, input int e);
		thr = t & 255;
		src = s;
		msk = m;
		dir = d;
		en = e;
		flag = 0;
		wr(OFS_THRESH, 8'(t));
		wr(OFS_AUX_CTRL, 8'(e * 16));
		repeat (2) wr(OFS_IRQ_CTRL, 8'(s * 4 + m * 2 + d));
		repeat (3) @(posedge ref_clk_i);
		hit_q = hitf(amp, raw);
	endtask : cfg
	task automatic give_verdict;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	initial
	begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		failures++;
		give_verdict();
	end
	initial
	begin
		{reset_n_i, wr_i, rd_i, addr_i, wdata_i, amp, raw} = '0;
		seed = 8'h61;
		repeat (8) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		rd("ctrl4", OFS_CTRL4, {1'b0, FOH_RESET, 5'h00});
		rd("thresh", OFS_THRESH, THRESH_RESET);
		wr(OFS_CTRL4, 8'hFF);
		rd("ctrl4", OFS_CTRL4, CTRL4_WMASK);
		chk("corner", 8'h01, {7'h00, rx_corner_sel_o});
		for (int a = OFS_RSVD_FIRST; a <= OFS_RSVD_LAST + 1; a++)
		begin
			seed = lfsr(seed);
			wr(6'(a), seed);
			rd("reg", 6'(a), a > OFS_RSVD_LAST ? seed : 8'h00);
		end
		rd("unmapped", 6'h3F, 8'h00);
		$display("map test done");
		for (int f = 0; f < 4; f++)
		begin
			wr(OFS_CTRL4, 8'(f * 32 + 8));
			@(posedge ref_clk_i);
			#1 chk("corner", 8'h00, {7'h00, rx_corner_sel_o});
			wr(OFS_AUX_CTRL, 8'h01);
			waitfor(0, 600);
			chk("offhook", 8'h01, 8'(k + 2 >= lens[f] && k <= lens[f] + 3));
			chk("seize", 8'h01, {7'h00, line_seize_o});
			wr(OFS_AUX_CTRL, 8'h00);
			waitfor(1, 200);
			chk("hangup_mid", 8'h01, 8'(k + 2 >= 15 && k <= 18));
		end
		wr(OFS_AUX_CTRL, 8'h0F);
		amp <= 8'h05;
		wr(OFS_AUX_CTRL, 8'h0E);
		waitfor(1, 40);
		chk("hangup_held", 8'h01, 8'(k == 40));
		amp <= 8'h00;
		waitfor(1, 40);
		chk("hangup_slow", 8'h01, 8'(k <= 3));
		wr(OFS_AUX_CTRL, 8'h0F);
		wr(OFS_AUX_CTRL, 8'h0E);
		waitfor(1, 40);
		chk("slow_len", 8'h01, 8'(k + 2 >= 25 && k <= 28));
		wr(OFS_CTRL4, 8'h60);
		wr(OFS_AUX_CTRL, 8'h01);
		wr(OFS_AUX_CTRL, 8'h00);
		waitfor(1, 30000);
		chk("hangup_fast", 8'h01, 8'(k + 2 >= HANGUP_FAST_CYC && k <= HANGUP_FAST_CYC + 3));
		$display("hook test done");
		for (int i = 0; i < 4; i++)
		begin
			cfg(50, 0, i % 2, 1, i / 2);
			step(8'h0A, 8'h00);
			step(8'h3C, 8'h00);
		end
		wr(OFS_IRQ_CTRL, 8'h0B);
		step(8'h3C, 8'h00);
		wr(OFS_IRQ_CTRL, 8'h03);
		flag = 0;
		step(8'h3C, 8'h00);
		cfg(50, 1, 1, 0, 1);
		step(8'h0A, 8'h9C);
		step(8'h0A, 8'h14);
		for (int i = 0; i < 16; i++)
		begin
			seed = lfsr(seed);
			if (i == 8) wr(OFS_CTRL4, 8'h01);
			cdis = i >= 8;
			if (i % 4 == 0) cfg(seed, i / 4 % 2, 1, i / 8, 1);
			step(seed, lfsr(seed));
		end
		$display("threshold test done");
		give_verdict();
	end
endmodule : test_line_side_control_and_threshold_irq
